// *** csic_pkg.sv ***
// Constants for the clamp, sync-on-green and input/power control bank.
// Assumes an APB3 slave with 32-bit data; registers sit in the low byte.
package csic_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CLAMP_TARGET  = 8'h18;
	localparam logic [7:0] IDX_START_DELAY   = 8'h19;
	localparam logic [7:0] IDX_PULSE_LENGTH  = 8'h1a;
	localparam logic [7:0] IDX_POL_OFFSET    = 8'h1b;
	localparam logic [7:0] IDX_FACTORY_TEST  = 8'h1c;
	localparam logic [7:0] IDX_GREEN_SYNC    = 8'h1d;
	localparam logic [7:0] IDX_INPUT_POWER   = 8'h1e;
	localparam logic [7:0] IDX_STATUS        = 8'h1f;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CLAMP_TARGET  = 8'h00;
	localparam logic [7:0] RST_START_DELAY   = 8'h08;
	localparam logic [7:0] RST_PULSE_LENGTH  = 8'h20;
	localparam logic [7:0] RST_POL_OFFSET    = 8'h5b;
	localparam logic [7:0] RST_FACTORY_TEST  = 8'hff;
	localparam logic [7:0] RST_GREEN_SYNC    = 8'h78;
	localparam logic [7:0] RST_INPUT_POWER   = 8'h30;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CT_RED          = 3;
	localparam int CT_GREEN        = 2;
	localparam int CT_BLUE         = 1;
	localparam int CT_SRC_EXT      = 4;
	localparam int PO_POL_OVR      = 7;
	localparam int PO_POL          = 6;
	localparam int PO_AUTO_EN      = 5;
	localparam int PO_RATE_HI      = 4;
	localparam int PO_RATE_LO      = 3;
	localparam int GS_THR_HI       = 7;
	localparam int GS_THR_LO       = 3;
	localparam int GS_POL          = 2;
	localparam int GS_SEL_HI       = 1;
	localparam int GS_SEL_LO       = 0;
	localparam int IP_CH_OVR       = 7;
	localparam int IP_CH_SEL       = 6;
	localparam int IP_BW_HIGH      = 5;
	localparam int IP_PD_AUTO      = 4;
	localparam int IP_PD           = 3;

	// ----------------------------------------------------------------
	// Auto-offset update rates
	// ----------------------------------------------------------------
	localparam logic [1:0] RATE_3_CLAMPS    = 2'h0;
	localparam logic [1:0] RATE_48_CLAMPS   = 2'h1;
	localparam logic [1:0] RATE_192_CLAMPS  = 2'h2;
	localparam logic [1:0] RATE_3_VSYNC     = 2'h3;
	localparam logic [7:0] CNT_3            = 8'h03;
	localparam logic [7:0] CNT_48           = 8'h30;
	localparam logic [7:0] CNT_192          = 8'hc0;

	// Green-sync output sources
	localparam logic [1:0] GSRC_RAW_GREEN   = 2'h0;
	localparam logic [1:0] GSRC_RAW_LINE    = 2'h1;
	localparam logic [1:0] GSRC_REGEN_LINE  = 2'h2;
	localparam logic [1:0] GSRC_FILT_LINE   = 2'h3;

	typedef enum logic [1:0] {
		CSIC_IDLE,
		CSIC_PLACE,
		CSIC_ACTIVE
	} csic_clamp_state_t;

endpackage

// *** csic_top.sv ***
// Clamp timing, auto-offset pacing, green-sync routing and input/power control.
// Assumes APB3 master on clock; all sync inputs are synchronous to clock,
// which is the pixel clock of the channel.

module csic_top (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        line_sync_inputs,
	input  wire logic        green_sync_inputs,
	input  wire logic        regen_line_sync,
	input  wire logic        filt_line_sync,
	input  wire logic        vsync_in,
	input  wire logic        ext_clamp_in,
	input  wire logic        auto_clamp_pol,
	input  wire logic        auto_chan_sel,
	input  wire logic        sync_on_ch0,
	input  wire logic        sync_on_ch1,
	input  wire logic        activity_lost,
	input  wire logic        pd_pin_active,
	output logic             clamp_out,
	output logic [2:0]       clamp_midscale,
	output logic             auto_offset_en,
	output logic             auto_offset_update,
	output logic [4:0]       slicer_threshold,
	output logic             green_sync_output,
	output logic             chan_sel,
	output logic             bw_high,
	output logic             power_down
);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] clamp_target_select_reg;
	logic [7:0] clamp_start_delay_reg;
	logic [7:0] clamp_pulse_length_reg;
	logic [7:0] clamp_polarity_and_auto_offset_reg;
	logic [7:0] factory_test_zero_reg;
	logic [7:0] green_sync_control_reg;
	logic [7:0] input_and_power_control_reg;

	logic       acc;
	logic       wr;
	logic [9:0] idx;
	logic       mapped;
	logic [7:0] rd_next;

	assign acc     = psel && penable;
	assign wr      = acc && pwrite;
	assign idx     = paddr[11:2];
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	always_comb begin
		mapped  = 1'b1;
		rd_next = 8'h00;
		case (idx[7:0])
			csic_pkg::IDX_CLAMP_TARGET: rd_next = clamp_target_select_reg;
			csic_pkg::IDX_START_DELAY:  rd_next = clamp_start_delay_reg;
			csic_pkg::IDX_PULSE_LENGTH: rd_next = clamp_pulse_length_reg;
			csic_pkg::IDX_POL_OFFSET:   rd_next = clamp_polarity_and_auto_offset_reg;
			csic_pkg::IDX_FACTORY_TEST: rd_next = factory_test_zero_reg;
			csic_pkg::IDX_GREEN_SYNC:   rd_next = green_sync_control_reg;
			csic_pkg::IDX_INPUT_POWER:  rd_next = input_and_power_control_reg;
			csic_pkg::IDX_STATUS:       rd_next = {5'h00, power_down, chan_sel, clamp_out};
			default:                    mapped  = 1'b0;
		endcase
		if (idx[9:8] != 2'h0 || paddr[1:0] != 2'h0) begin
			mapped  = 1'b0;
			rd_next = 8'h00;
		end
	end

	// Zero-wait slave: read data is combinational on the access cycle
	assign prdata = (acc && !pwrite) ? {24'h0000_00, rd_next} : 32'h0000_0000;

	// ----------------------------------------------------------------
	// Write strobes, one per register
	// ----------------------------------------------------------------
	// Strobes are gated by the decode, so unmapped or misaligned
	// writes never touch a register.
	logic we_target;
	logic we_delay;
	logic we_length;
	logic we_pol;
	logic we_test;
	logic we_green;
	logic we_input;

	assign we_target = wr && mapped && (idx[7:0] == csic_pkg::IDX_CLAMP_TARGET);
	assign we_delay  = wr && mapped && (idx[7:0] == csic_pkg::IDX_START_DELAY);
	assign we_length = wr && mapped && (idx[7:0] == csic_pkg::IDX_PULSE_LENGTH);
	assign we_pol    = wr && mapped && (idx[7:0] == csic_pkg::IDX_POL_OFFSET);
	assign we_test   = wr && mapped && (idx[7:0] == csic_pkg::IDX_FACTORY_TEST);
	assign we_green  = wr && mapped && (idx[7:0] == csic_pkg::IDX_GREEN_SYNC);
	assign we_input  = wr && mapped && (idx[7:0] == csic_pkg::IDX_INPUT_POWER);

	always_ff @(posedge clock) begin
		if (rst)
			clamp_target_select_reg <= csic_pkg::RST_CLAMP_TARGET;
		else if (we_target)
			clamp_target_select_reg <= pwdata[7:0];
	end

	always_ff @(posedge clock) begin
		if (rst)
			clamp_start_delay_reg <= csic_pkg::RST_START_DELAY;
		else if (we_delay)
			clamp_start_delay_reg <= pwdata[7:0];
	end

	always_ff @(posedge clock) begin
		if (rst)
			clamp_pulse_length_reg <= csic_pkg::RST_PULSE_LENGTH;
		else if (we_length)
			clamp_pulse_length_reg <= pwdata[7:0];
	end

	// Reserved low bits are stored as written; keeping them at the
	// required pattern is up to software.
	always_ff @(posedge clock) begin
		if (rst)
			clamp_polarity_and_auto_offset_reg <= csic_pkg::RST_POL_OFFSET;
		else if (we_pol)
			clamp_polarity_and_auto_offset_reg <= pwdata[7:0];
	end

	always_ff @(posedge clock) begin
		if (rst)
			factory_test_zero_reg <= csic_pkg::RST_FACTORY_TEST;
		else if (we_test)
			factory_test_zero_reg <= pwdata[7:0];
	end

	always_ff @(posedge clock) begin
		if (rst)
			green_sync_control_reg <= csic_pkg::RST_GREEN_SYNC;
		else if (we_green)
			green_sync_control_reg <= pwdata[7:0];
	end

	always_ff @(posedge clock) begin
		if (rst)
			input_and_power_control_reg <= csic_pkg::RST_INPUT_POWER;
		else if (we_input)
			input_and_power_control_reg <= pwdata[7:0];
	end

	// ----------------------------------------------------------------
	// Internal clamp timing
	// ----------------------------------------------------------------
	logic                        line_sync_d_reg;
	logic                        line_trail;
	logic                        clamp_pol_pos;
	logic                        internal_clamp;
	logic [7:0]                  clamp_cnt_reg;
	csic_pkg::csic_clamp_state_t clamp_state_reg;

	// Polarity is applied before edge detection so the trailing edge is
	// always the end of the active sync level.
	always_comb begin
		if (clamp_polarity_and_auto_offset_reg[csic_pkg::PO_POL_OVR])
			clamp_pol_pos = clamp_polarity_and_auto_offset_reg[csic_pkg::PO_POL];
		else
			clamp_pol_pos = auto_clamp_pol;
	end

	always_ff @(posedge clock) begin
		if (rst)
			line_sync_d_reg <= 1'b0;
		else
			line_sync_d_reg <= line_sync_inputs;
	end

	always_comb begin
		if (clamp_pol_pos)
			line_trail = line_sync_d_reg && !line_sync_inputs;
		else
			line_trail = !line_sync_d_reg && line_sync_inputs;
	end

	// A zero placement starts the pulse on the clock after the edge; a zero
	// duration yields no pulse at all.
	always_ff @(posedge clock) begin
		if (rst) begin
			clamp_state_reg <= csic_pkg::CSIC_IDLE;
			clamp_cnt_reg   <= 8'h00;
		end else if (line_trail) begin
			clamp_cnt_reg <= clamp_start_delay_reg;
			if (clamp_start_delay_reg != 8'h00)
				clamp_state_reg <= csic_pkg::CSIC_PLACE;
			else if (clamp_pulse_length_reg != 8'h00) begin
				clamp_state_reg <= csic_pkg::CSIC_ACTIVE;
				clamp_cnt_reg   <= clamp_pulse_length_reg;
			end else
				clamp_state_reg <= csic_pkg::CSIC_IDLE;
		end else begin
			case (clamp_state_reg)
				csic_pkg::CSIC_IDLE: ;
				csic_pkg::CSIC_PLACE: begin
					if (clamp_cnt_reg == 8'h01) begin
						clamp_cnt_reg <= clamp_pulse_length_reg;
						clamp_state_reg <= (clamp_pulse_length_reg != 8'h00) ?
							csic_pkg::CSIC_ACTIVE : csic_pkg::CSIC_IDLE;
					end else
						clamp_cnt_reg <= clamp_cnt_reg - 8'h01;
				end
				csic_pkg::CSIC_ACTIVE: begin
					if (clamp_cnt_reg == 8'h01)
						clamp_state_reg <= csic_pkg::CSIC_IDLE;
					clamp_cnt_reg <= clamp_cnt_reg - 8'h01;
				end
				default: clamp_state_reg <= csic_pkg::CSIC_IDLE;
			endcase
		end
	end

	assign internal_clamp = (clamp_state_reg == csic_pkg::CSIC_ACTIVE);

	// External clamp is taken active-high as presented at the pin
	always_ff @(posedge clock) begin
		if (rst)
			clamp_out <= 1'b0;
		else if (clamp_target_select_reg[csic_pkg::CT_SRC_EXT])
			clamp_out <= ext_clamp_in;
		else
			clamp_out <= internal_clamp;
	end

	assign clamp_midscale = {clamp_target_select_reg[csic_pkg::CT_RED],
	                         clamp_target_select_reg[csic_pkg::CT_GREEN],
	                         clamp_target_select_reg[csic_pkg::CT_BLUE]};

	// ----------------------------------------------------------------
	// Auto-offset pacing
	// ----------------------------------------------------------------
	logic       clamp_d_reg;
	logic       clamp_end;
	logic       vsync_d_reg;
	logic       vsync_rise;
	logic [7:0] pace_cnt_reg;
	logic [1:0] rate;
	logic [7:0] pace_target;
	logic       pace_event;

	assign rate = clamp_polarity_and_auto_offset_reg[csic_pkg::PO_RATE_HI:csic_pkg::PO_RATE_LO];
	assign auto_offset_en = clamp_polarity_and_auto_offset_reg[csic_pkg::PO_AUTO_EN];

	always_ff @(posedge clock) begin
		if (rst) begin
			clamp_d_reg <= 1'b0;
			vsync_d_reg <= 1'b0;
		end else begin
			clamp_d_reg <= clamp_out;
			vsync_d_reg <= vsync_in;
		end
	end

	assign clamp_end  = clamp_d_reg && !clamp_out;
	assign vsync_rise = vsync_in && !vsync_d_reg;

	always_comb begin
		case (rate)
			csic_pkg::RATE_3_CLAMPS:   pace_target = csic_pkg::CNT_3;
			csic_pkg::RATE_48_CLAMPS:  pace_target = csic_pkg::CNT_48;
			csic_pkg::RATE_192_CLAMPS: pace_target = csic_pkg::CNT_192;
			default:                   pace_target = csic_pkg::CNT_3;
		endcase
	end

	assign pace_event = (rate == csic_pkg::RATE_3_VSYNC) ? vsync_rise : clamp_end;

	always_ff @(posedge clock) begin
		if (rst || !auto_offset_en) begin
			pace_cnt_reg       <= 8'h00;
			auto_offset_update <= 1'b0;
		end else begin
			auto_offset_update <= 1'b0;
			if (pace_event) begin
				if (pace_cnt_reg + 8'h01 >= pace_target) begin
					pace_cnt_reg       <= 8'h00;
					auto_offset_update <= 1'b1;
				end else
					pace_cnt_reg <= pace_cnt_reg + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Green-sync output
	// ----------------------------------------------------------------
	logic gs_raw;

	assign slicer_threshold = green_sync_control_reg[csic_pkg::GS_THR_HI:csic_pkg::GS_THR_LO];

	always_comb begin
		case (green_sync_control_reg[csic_pkg::GS_SEL_HI:csic_pkg::GS_SEL_LO])
			csic_pkg::GSRC_RAW_GREEN:  gs_raw = green_sync_inputs;
			csic_pkg::GSRC_RAW_LINE:   gs_raw = line_sync_inputs;
			csic_pkg::GSRC_REGEN_LINE: gs_raw = regen_line_sync;
			csic_pkg::GSRC_FILT_LINE:  gs_raw = filt_line_sync;
			default:                   gs_raw = green_sync_inputs;
		endcase
	end

	// Sources are taken active-high; negative polarity inverts the pin
	always_ff @(posedge clock) begin
		if (rst)
			green_sync_output <= 1'b1;
		else if (green_sync_control_reg[csic_pkg::GS_POL])
			green_sync_output <= gs_raw;
		else
			green_sync_output <= !gs_raw;
	end

	// ----------------------------------------------------------------
	// Input channel, bandwidth and power
	// ----------------------------------------------------------------
	logic ch_prog;

	assign ch_prog = input_and_power_control_reg[csic_pkg::IP_CH_SEL];
	assign bw_high = input_and_power_control_reg[csic_pkg::IP_BW_HIGH];

	always_ff @(posedge clock) begin
		if (rst)
			chan_sel <= 1'b0;
		else if (input_and_power_control_reg[csic_pkg::IP_CH_OVR])
			chan_sel <= ch_prog;
		else if (sync_on_ch0 && sync_on_ch1)
			chan_sel <= ch_prog;
		else
			chan_sel <= auto_chan_sel;
	end

	// Power-down bit forces it on; otherwise auto mode powers down on loss of activity and manual mode follows the pin
	always_ff @(posedge clock) begin
		if (rst)
			power_down <= 1'b0;
		else if (input_and_power_control_reg[csic_pkg::IP_PD])
			power_down <= 1'b1;
		else if (input_and_power_control_reg[csic_pkg::IP_PD_AUTO])
			power_down <= activity_lost;
		else
			power_down <= pd_pin_active;
	end

endmodule

// *** csic_sva.sv ***
// Checker for the clamp, green-sync and input/power control bank.
// Assumes zero-wait APB on clock and synchronous active-high rst.
module csic_sva (
	input logic        clock,
	input logic        rst,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic        auto_chan_sel,
	input logic        sync_on_ch0,
	input logic        sync_on_ch1,
	input logic        activity_lost,
	input logic        pd_pin_active,
	input logic        clamp_out,
	input logic [2:0]  clamp_midscale,
	input logic        auto_offset_en,
	input logic        auto_offset_update,
	input logic [4:0]  slicer_threshold,
	input logic        chan_sel,
	input logic        bw_high,
	input logic        power_down
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ------------------------------
	// Shadow of input/power register
	// ------------------------------
	logic       wr;
	logic       pd_exp;
	logic       ch_exp;
	logic [7:0] ip_reg;
	assign wr = psel && penable && pwrite && paddr[1:0] == 2'h0;
	function automatic logic hit(logic [7:0] idx);
		return wr && paddr[11:2] == {2'h0, idx};
	endfunction
	always_ff @(posedge clock) begin
		if (rst)
			ip_reg <= csic_pkg::RST_INPUT_POWER;
		else if (hit(csic_pkg::IDX_INPUT_POWER))
			ip_reg <= pwdata[7:0];
	end
	// Inputs are sampled raw, so both outputs lag their cause by one edge
	assign pd_exp = ip_reg[3] | (ip_reg[4] ? activity_lost : pd_pin_active);
	assign ch_exp = (ip_reg[7] | sync_on_ch0 & sync_on_ch1) ? ip_reg[6] : auto_chan_sel;
	AST_MIDSCALE: assert property (hit(csic_pkg::IDX_CLAMP_TARGET) |=>
		clamp_midscale == $past(pwdata[3:1])) else $error("clamp target mismatch");
	AST_AUTO_EN: assert property (hit(csic_pkg::IDX_POL_OFFSET) |=>
		auto_offset_en == $past(pwdata[5])) else $error("auto-offset enable mismatch");
	AST_THRESHOLD: assert property (hit(csic_pkg::IDX_GREEN_SYNC) |=>
		slicer_threshold == $past(pwdata[7:3])) else $error("threshold mismatch");
	AST_BANDWIDTH: assert property (hit(csic_pkg::IDX_INPUT_POWER) |=>
		bw_high == $past(pwdata[5])) else $error("bandwidth mismatch");
	AST_PD_FORCED: assert property (hit(csic_pkg::IDX_INPUT_POWER) && pwdata[3] |->
		##2 power_down [*2]) else $error("power-down not forced");
	AST_PD_SOURCE: assert property (1'b1 |=> power_down == $past(pd_exp))
		else $error("power-down source mismatch");
	AST_CHAN_SEL: assert property (1'b1 |=> chan_sel == $past(ch_exp))
		else $error("channel select mismatch");
	AST_UPDATE_PULSE: assert property (auto_offset_update |=> !auto_offset_update)
		else $error("update pulse too long");
	CV_CLAMP: cover property ($fell(clamp_out));
	CV_UPDATE: cover property (auto_offset_update);
	CV_PD: cover property ($rose(power_down));
endmodule

bind csic_top csic_sva chk_u (.*);

// *** tb_top.sv ***
// Self-checking bench for csic_top: registers, clamp timing, auto-offset
// pacing and routed outputs. Assumes byte address is four times the index.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        line_sync_inputs, green_sync_inputs, regen_line_sync, filt_line_sync;
	logic        vsync_in, ext_clamp_in, auto_clamp_pol, auto_chan_sel, sync_on_ch0;
	logic        sync_on_ch1, activity_lost, pd_pin_active, clamp_out, auto_offset_en;
	logic        auto_offset_update, green_sync_output, chan_sel, bw_high, power_down;
	logic [2:0]  clamp_midscale;
	logic [4:0]  slicer_threshold;
	logic [7:0]  mdl [7] = '{8'h00, 8'h08, 8'h20, 8'h5b, 8'hff, 8'h78, 8'h30};
	int          n_ev [4] = '{3, 48, 192, 3};
	int          err_total, check_count, upd_cnt, p, d;
	bit          pos, ext;
	csic_top dut_u (.*);
	initial begin
		clock = 0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock)
		if (auto_offset_update === 1'b1) upd_cnt++;
	// ------------------------------
	// Bus and compare tasks
	// ------------------------------
	task automatic chk(input logic [39:0] got, exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		int n;
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
		@(posedge clock);
		penable <= 1;
		n = 0;
		do @(posedge clock); while (pready !== 1'b1 && ++n < 64);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic wreg(input int k, input logic [7:0] v);
		apb(1, 12'h060 + 12'(4 * k), {24'($urandom), v});
		mdl[k] = v;
	endtask
	task automatic rreg(input int k);
		apb(0, 12'h060 + 12'(4 * k), 32'h0);
		chk({e, r}, {9'h0, mdl[k]});
	endtask
	task automatic side();
		logic        src;
		logic [12:0] x, y;
		repeat (2) @(posedge clock);
		#1;
		src = mdl[5][1] ? (mdl[5][0] ? filt_line_sync : regen_line_sync)
			: (mdl[5][0] ? line_sync_inputs : green_sync_inputs);
		x = {mdl[0][3:1], mdl[3][5], mdl[5][7:3], src ^ ~mdl[5][2],
			(mdl[6][7] | sync_on_ch0 & sync_on_ch1) ? mdl[6][6] : auto_chan_sel,
			mdl[6][5], mdl[6][3] | (mdl[6][4] ? activity_lost : pd_pin_active)};
		y = {clamp_midscale, auto_offset_en, slicer_threshold, green_sync_output, chan_sel,
			bw_high, power_down};
		chk(40'(y), 40'(x));
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		end_sim();
	end
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		void'($urandom(32'h1b15));
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1;
		{line_sync_inputs, green_sync_inputs, regen_line_sync, filt_line_sync, vsync_in} = '0;
		{ext_clamp_in, auto_clamp_pol, auto_chan_sel, sync_on_ch0, sync_on_ch1} = '0;
		{activity_lost, pd_pin_active} = '0;
		repeat (2) @(posedge clock);
		rst <= 0;
		for (int k = 0; k < 7; k++) rreg(k);
		side();
		apb(1, 12'h080, 32'h0000_00aa);
		chk(e, 1);
		apb(0, 12'h080, 32'h0);
		chk({e, r}, 40'h01_0000_0000);
		apb(1, 12'h065, 32'h0000_0077);
		chk(e, 1);
		rreg(1);
		for (int i = 0; i < 16; i++) begin
			wreg(0, 8'($urandom) & 8'hee);
			wreg(5, {5'($urandom), i[2:0]});
			wreg(6, 8'($urandom));
			@(posedge clock);
			{line_sync_inputs, green_sync_inputs, regen_line_sync, filt_line_sync, auto_chan_sel,
				sync_on_ch0, sync_on_ch1, activity_lost, pd_pin_active} <= 9'($urandom);
			side();
			rreg(6);
		end
		// Last case selects the external source, so no internal pulse may show
		for (int i = 0; i < 6; i++) begin
			p = $urandom_range(4);
			d = $urandom_range(4);
			ext = (i == 5);
			wreg(0, {3'h0, ext, 4'h0});
			wreg(1, 8'(p));
			wreg(2, 8'(d));
			wreg(3, {i[1:0], 6'h1b});
			@(posedge clock);
			pos = i[1] ? i[0] : 1'($urandom);
			auto_clamp_pol <= i[1] ? ~pos : pos;
			line_sync_inputs <= pos;
			repeat (48) @(posedge clock);
			line_sync_inputs <= ~pos;
			for (int k = 1; k < p + d + 4; k++) begin
				@(posedge clock);
				#1;
				chk(clamp_out, !ext && k >= p + 2 && k <= p + d + 1);
			end
		end
		@(posedge clock);
		{line_sync_inputs, vsync_in} <= 2'b00;
		repeat (20) @(posedge clock);
		wreg(0, 8'h00);
		wreg(1, 8'h01);
		wreg(2, 8'h02);
		for (int c = 0; c < 4; c++) begin
			wreg(3, {3'h6, c[1:0], 3'h3});
			wreg(3, {3'h7, c[1:0], 3'h3});
			p = upd_cnt;
			repeat (n_ev[c]) begin
				@(posedge clock);
				{line_sync_inputs, vsync_in} <= c == 3 ? 2'b01 : 2'b10;
				repeat (3) @(posedge clock);
				{line_sync_inputs, vsync_in} <= 2'b00;
				repeat (8) @(posedge clock);
			end
			chk(40'(upd_cnt - p), 40'h1);
		end
		end_sim();
	end
endmodule
